// [core/masd_decode.sv]
// top of the module address and space decoder
// ------------------------------------------------------------
// Overview of operation
// - block selected when addr[23:20] equals M111
// - unused locations and bits read zero
// - vectors from supervisor data, reset from program
// - only reset vector fixed; table follows base
// - vector address is base[31:10], number, 00
// - some registers refused in user space
// - some unused forwarded externally; reserved never
// - base addresses 1024-byte table of 256 vectors
// - function code shows state and space
// ------------------------------------------------------------
`default_nettype none
module masd_decode
    import masd_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 module_map_signal_in,
    input  wire masd_req_t            req_in,
    input  wire logic [DATA_W-1:0]    reg_rdata_in,
    input  wire logic                 supervisor_in,
    input  wire logic                 program_in,
    input  wire logic                 cpu_space_in,
    input  wire logic                 vbr_wr_in,
    input  wire logic [VBR_W-1:0]     vbr_wdata_in,
    input  wire logic                 vec_req_in,
    input  wire logic                 vec_is_reset_in,
    input  wire logic [VEC_NUM_W-1:0] vec_num_in,
    output masd_resp_t                resp_out,
    output logic                      reg_sel_out,
    output logic                      ext_sel_out,
    output logic [2:0]                function_code_out,
    output logic [VBR_W-1:0]          vector_table_base_out,
    output logic                      vec_valid_out,
    output logic [VBR_W-1:0]          vec_addr_out,
    output logic [2:0]                vec_fc_out
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic blk_hit(input logic [ADDR_W-1:0] a, input logic m);
        blk_hit = (a[BLK_HI:BLK_LO] == {m, BLK_LOW_PATTERN});
    endfunction : blk_hit

    function automatic logic [3:0] region_of(input logic [ADDR_W-1:0] a);
        region_of = a[BLK_OFS_W-1:BLK_OFS_W-4];
    endfunction : region_of

    // inclusive bounds on a region index
    function automatic logic in_range(input logic [3:0] r, input logic [3:0] lo, input logic [3:0] hi);
        in_range = (r >= lo) && (r <= hi);
    endfunction : in_range

    function automatic masd_target_t classify(input logic [ADDR_W-1:0] a, input logic m,
                                              input logic [2:0] fc);
        logic [3:0] region;
        region = region_of(a);
        if (!blk_hit(a, m)) begin
            classify = MASD_TGT_EXT;
        end else if (region == REG_SUPV_ONLY_HI) begin
            classify = fc[2] ? MASD_TGT_REG : MASD_TGT_DENY;
        end else if (in_range(region, REG_USER_LO, REG_USER_HI)) begin
            classify = MASD_TGT_REG;
        end else if (in_range(region, REG_EXT_LO, REG_EXT_HI)) begin
            classify = MASD_TGT_EXT;
        end else begin
            classify = MASD_TGT_ZERO;
        end
    endfunction : classify

    // cpu space cycles override both privilege and program/data
    function automatic logic [2:0] fc_of(input logic sup, input logic prog, input logic cpu);
        if (cpu) begin
            fc_of = FC_CPU_SPACE;
        end else if (sup) begin
            fc_of = prog ? FC_SUPV_PROG : FC_SUPV_DATA;
        end else begin
            fc_of = prog ? FC_USER_PROG : FC_USER_DATA;
        end
    endfunction : fc_of

    // only implemented bits of a reached register pass, all else reads zero
    function automatic logic [DATA_W-1:0] read_word(input logic [DATA_W-1:0] raw, input logic hit);
        read_word = hit ? (raw & REG_IMPL_MASK) : '0;
    endfunction : read_word

    // ------------------------------------------------------------
    // mapping bit synchroniser (pin domain)
    // ------------------------------------------------------------
    logic [2:0] map_sync;
    logic       module_map_select;
    masd_target_t tgt;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            map_sync <= 3'h0;
        end else begin
            map_sync <= {map_sync[1:0], module_map_signal_in};
        end
    end

    // change counts once the last two stages agree
    logic next_map;

    assign next_map = (map_sync[1] == map_sync[2]) ? map_sync[2] : module_map_select;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            module_map_select <= 1'b0;
        end else begin
            module_map_select <= next_map;
        end
    end

    // ------------------------------------------------------------
    // target decode
    // ------------------------------------------------------------
    // current mapping bit used for each access, no latching per cycle
    assign tgt = classify(req_in.addr, module_map_select, req_in.fc);

    // ------------------------------------------------------------
    // access response
    // ------------------------------------------------------------
    masd_resp_t next_resp;
    logic       reg_hit;
    logic       ext_hit;

    always_comb begin
        reg_hit          = req_in.valid && tgt == MASD_TGT_REG;
        ext_hit          = req_in.valid && tgt == MASD_TGT_EXT;
        next_resp.valid  = req_in.valid;
        next_resp.target = tgt;
        next_resp.rdata  = read_word(reg_rdata_in, reg_hit && req_in.rnw);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            resp_out <= '0;
        end else begin
            resp_out <= next_resp;
        end
    end

    // ------------------------------------------------------------
    // register and external selects
    // ------------------------------------------------------------
    // a refused user access selects nothing
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_sel_out <= 1'b0;
        end else begin
            reg_sel_out <= reg_hit;
        end
    end

    // reserved offsets never reach the external bus
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ext_sel_out <= 1'b0;
        end else begin
            ext_sel_out <= ext_hit;
        end
    end

    // ------------------------------------------------------------
    // function code output
    // ------------------------------------------------------------
    logic [2:0] next_fc;

    assign next_fc = fc_of(supervisor_in, program_in, cpu_space_in);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            function_code_out <= FC_SUPV_PROG;
        end else begin
            function_code_out <= next_fc;
        end
    end

    // ------------------------------------------------------------
    // vector table base
    // ------------------------------------------------------------
    logic [VBR_W-1:0] next_vbr;

    // low ten bits dropped: the 1024-byte table is always aligned
    always_comb begin
        next_vbr = vector_table_base_out;
        if (vbr_wr_in) begin
            next_vbr = {vbr_wdata_in[VBR_W-1:VBR_KEEP_LSB], 10'h000};
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vector_table_base_out <= VBR_RESET;
        end else begin
            vector_table_base_out <= next_vbr;
        end
    end

    // ------------------------------------------------------------
    // vector fetch
    // ------------------------------------------------------------
    // address and space registered together so they never disagree
    masd_vec_gen u_vec_gen (
        .clk_in          (clk_in),
        .resetn_in       (resetn_in),
        .vec_req_in      (vec_req_in),
        .vec_is_reset_in (vec_is_reset_in),
        .vec_num_in      (vec_num_in),
        .vbr_in          (vector_table_base_out),
        .vec_valid_out   (vec_valid_out),
        .vec_addr_out    (vec_addr_out),
        .vec_fc_out      (vec_fc_out)
    );
endmodule : masd_decode
`default_nettype wire

// [core/masd_pkg.sv]
// package of constants and carrier types for the module address and space decoder
`default_nettype none
package masd_pkg;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int ADDR_W        = 24;
    localparam int DATA_W        = 16;
    localparam int VEC_NUM_W     = 8;
    localparam int VBR_W         = 32;
    localparam int VBR_KEEP_LSB  = 10;  // upper 22 bits of base kept
    localparam int BLK_HI        = 23;
    localparam int BLK_LO        = 20;
    localparam int BLK_OFS_W     = 12;  // offset inside register block
    // ------------------------------------------------------------
    // constant values
    // ------------------------------------------------------------
    localparam logic [2:0] BLK_LOW_PATTERN = 3'h7;
    localparam logic [31:0] VBR_RESET      = 32'h0000_0000;
    localparam logic [31:0] RESET_VEC_ADDR = 32'h0000_0000;
    localparam int VEC_TABLE_BYTES = 1024;
    localparam int VEC_COUNT       = 256;
    // function codes
    localparam logic [2:0] FC_USER_DATA  = 3'h1;
    localparam logic [2:0] FC_USER_PROG  = 3'h2;
    localparam logic [2:0] FC_SUPV_DATA  = 3'h5;
    localparam logic [2:0] FC_SUPV_PROG  = 3'h6;
    localparam logic [2:0] FC_CPU_SPACE  = 3'h7;
    // region map inside the register block, by offset bits [11:8]
    localparam logic [3:0] REG_SUPV_ONLY_HI = 4'h0; // 0x000-0x0ff supervisor only
    localparam logic [3:0] REG_USER_LO      = 4'h1; // 0x100-0x7ff implemented, any space
    localparam logic [3:0] REG_USER_HI      = 4'h7;
    localparam logic [3:0] REG_EXT_LO       = 4'h8; // 0x800-0xbff forwarded externally
    localparam logic [3:0] REG_EXT_HI       = 4'hb; // 0xc00-0xfff reserved
    localparam logic [15:0] REG_IMPL_MASK   = 16'h00ff; // implemented bits per location

    typedef enum logic [1:0] {
        MASD_TGT_EXT  = 2'b00,
        MASD_TGT_REG  = 2'b01,
        MASD_TGT_ZERO = 2'b10,
        MASD_TGT_DENY = 2'b11
    } masd_target_t;

    typedef struct packed {
        logic                valid;
        logic                rnw;
        logic [2:0]          fc;
        logic [ADDR_W-1:0]   addr;
    } masd_req_t;

    typedef struct packed {
        logic                valid;
        masd_target_t        target;
        logic [DATA_W-1:0]   rdata;
    } masd_resp_t;
endpackage : masd_pkg
`default_nettype wire

// [core/masd_vec_gen.sv]
// vector address and space generator for exception fetches
`default_nettype none
module masd_vec_gen
    import masd_pkg::*;
(
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 vec_req_in,
    input  wire logic                 vec_is_reset_in,
    input  wire logic [VEC_NUM_W-1:0] vec_num_in,
    input  wire logic [VBR_W-1:0]     vbr_in,
    output logic                      vec_valid_out,
    output logic [VBR_W-1:0]          vec_addr_out,
    output logic [2:0]                vec_fc_out
);
    // ------------------------------------------------------------
    // registered vector fetch
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            vec_valid_out <= 1'b0;
            vec_addr_out  <= 32'h0000_0000;
            vec_fc_out    <= 3'h0;
        end else begin
            vec_valid_out <= vec_req_in;
            if (vec_req_in) begin
                if (vec_is_reset_in) begin
                    vec_addr_out <= RESET_VEC_ADDR;
                    vec_fc_out   <= FC_SUPV_PROG;
                end else begin
                    // upper 22 bits of base, vector number, two zero bits
                    vec_addr_out <= {vbr_in[VBR_W-1:VBR_KEEP_LSB], vec_num_in, 2'h0};
                    vec_fc_out   <= FC_SUPV_DATA;
                end
            end
        end
    end
endmodule : masd_vec_gen
`default_nettype wire

// [test/masd_asserts.sv]
// checker for the address and space decoder
`default_nettype none
module masd_asserts
    import masd_pkg::*;
(
    input wire logic                 clk_in,
    input wire logic                 resetn_in,
    input wire masd_req_t            req_in,
    input wire masd_resp_t           resp_out,
    input wire logic                 reg_sel_out,
    input wire logic                 ext_sel_out,
    input wire logic                 vec_req_in,
    input wire logic                 vec_is_reset_in,
    input wire logic [VEC_NUM_W-1:0] vec_num_in,
    input wire logic [VBR_W-1:0]     vector_table_base_out,
    input wire logic [VBR_W-1:0]     vec_addr_out,
    input wire logic [2:0]           vec_fc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    chk_answer_next: assert property (req_in.valid |=> resp_out.valid) else $error("no answer");
    chk_block_base: assert property (reg_sel_out |-> $past(req_in.addr[22:20]) == 3'h7) else $error("base");
    chk_upper_zero: assert property (resp_out.valid |-> resp_out.rdata[15:8] == 8'h0) else $error("bits");
    chk_user_refused: assert property (resp_out.valid && resp_out.target == MASD_TGT_DENY |->
        !$past(req_in.fc[2]) && !reg_sel_out && resp_out.rdata == 16'h0) else $error("deny");
    chk_reserved_local: assert property (resp_out.valid && resp_out.target == MASD_TGT_ZERO |->
        !ext_sel_out && !reg_sel_out) else $error("reserved forwarded");
    chk_ext_target: assert property (ext_sel_out |->
        resp_out.valid && resp_out.target == MASD_TGT_EXT) else $error("ext");
    chk_vec_form: assert property (vec_req_in && !vec_is_reset_in |=>
        vec_addr_out == {$past(vector_table_base_out[31:10]), $past(vec_num_in), 2'b00}) else $error("vector");
    chk_reset_vec: assert property (vec_req_in && vec_is_reset_in |=>
        vec_addr_out == RESET_VEC_ADDR && vec_fc_out == FC_SUPV_PROG) else $error("reset vector");
    cover property (resp_out.valid && resp_out.target == MASD_TGT_DENY);
    cover property (reg_sel_out);
    cover property (vec_req_in && vec_is_reset_in);
endmodule : masd_asserts
bind masd_decode masd_asserts chk (.clk_in, .resetn_in, .req_in, .resp_out, .reg_sel_out, .ext_sel_out,
    .vec_req_in, .vec_is_reset_in, .vec_num_in, .vector_table_base_out, .vec_addr_out, .vec_fc_out);
`default_nettype wire

// [test/masd_core_model.sv]
// far side model: internal register data source
`default_nettype none
module masd_core_model
    import masd_pkg::*;
(
    input  wire masd_req_t        req_in,
    input  wire logic [2:0]       function_code_in,
    output logic [DATA_W-1:0]     rdata_out,
    output logic                  space_sup_out,
    output logic [1:0]            space_four_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // upper byte set so leaked unused bits show; idle bus shows a foreign pattern
    assign rdata_out = req_in.valid ? {8'hc3, req_in.addr[7:0]} : 16'ha5a5;
    // two-space decoder looks at the top code bit only
    assign space_sup_out  = function_code_in[2];
    // full decoder: privilege and program/data give four spaces
    assign space_four_out = function_code_in[2:1];
endmodule : masd_core_model
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the address and space decoder
`default_nettype none
module tb
    import masd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, resetn_in = 1'b0, module_map_signal_in = 1'b0;
    logic supervisor_in = 1'b1, program_in = 1'b0, cpu_space_in = 1'b0;
    logic vbr_wr_in = 1'b0, vec_req_in = 1'b0, vec_is_reset_in = 1'b0;
    logic [VBR_W-1:0] vbr_wdata_in = '0;
    logic [VEC_NUM_W-1:0] vec_num_in = '0;
    masd_req_t req_in = '0;
    logic [DATA_W-1:0] reg_rdata_in;
    masd_resp_t resp_out;
    logic reg_sel_out, ext_sel_out, vec_valid_out;
    logic [2:0] function_code_out, vec_fc_out;
    logic [VBR_W-1:0] vector_table_base_out, vec_addr_out;
    logic space_sup;
    logic [1:0] space_four;
    int err_total = 0, checks_done = 0;
    always #50 clk_in = ~clk_in;
    masd_decode dut (.clk_in, .resetn_in, .module_map_signal_in, .req_in, .reg_rdata_in, .supervisor_in,
        .program_in, .cpu_space_in, .vbr_wr_in, .vbr_wdata_in, .vec_req_in, .vec_is_reset_in, .vec_num_in,
        .resp_out, .reg_sel_out, .ext_sel_out, .function_code_out, .vector_table_base_out, .vec_valid_out,
        .vec_addr_out, .vec_fc_out);
    masd_core_model core (.req_in, .function_code_in(function_code_out), .rdata_out(reg_rdata_in),
        .space_sup_out(space_sup), .space_four_out(space_four));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask : tick
    // valid left high so calls run back to back
    task automatic access(input logic [2:0] f, input logic [23:0] a, input logic r, input masd_target_t t);
        req_in = '{1'b1, r, f, a};
        tick();
        check({resp_out, reg_sel_out, ext_sel_out}, {1'b1, t, (t == MASD_TGT_REG && r) ? {8'h0, a[7:0]} : 16'h0,
            t == MASD_TGT_REG, t == MASD_TGT_EXT});
    endtask : access
    task automatic accesses;
        access(FC_SUPV_DATA, 24'h7ff100, 1'b1, MASD_TGT_REG);
        access(FC_USER_DATA, 24'h7ff0ff, 1'b1, MASD_TGT_DENY);
        access(FC_SUPV_PROG, 24'h7ff0ff, 1'b1, MASD_TGT_REG);
        access(FC_USER_PROG, 24'h7ff7ff, 1'b0, MASD_TGT_REG);
        access(FC_USER_DATA, 24'h7ff800, 1'b1, MASD_TGT_EXT);
        access(FC_SUPV_DATA, 24'h7ffbff, 1'b1, MASD_TGT_EXT);
        access(FC_USER_DATA, 24'h7ffc00, 1'b1, MASD_TGT_ZERO);
        access(FC_SUPV_DATA, 24'hfff100, 1'b1, MASD_TGT_EXT);
        req_in.valid = 1'b0;
        module_map_signal_in = 1'b1;
        repeat (5) tick();
        access(FC_SUPV_DATA, 24'hfff100, 1'b1, MASD_TGT_REG);
        access(FC_SUPV_DATA, 24'h7ff100, 1'b1, MASD_TGT_EXT);
        req_in.valid = 1'b0;
    endtask : accesses
    task automatic vectors;
        vbr_wdata_in = 32'h1234_5678;
        vbr_wr_in = 1'b1;
        tick();
        vbr_wr_in = 1'b0;
        check(vector_table_base_out, 32'h1234_5400);
        vec_req_in = 1'b1;
        vec_num_in = 8'hff;
        tick();
        check({vec_valid_out, vec_addr_out, vec_fc_out}, {1'b1, 32'h1234_57fc, FC_SUPV_DATA});
        vec_is_reset_in = 1'b1;
        tick();
        vec_req_in = 1'b0;
        check({vec_addr_out, vec_fc_out}, {RESET_VEC_ADDR, FC_SUPV_PROG});
        tick();
        check({vec_valid_out, vec_fc_out}, {1'b0, FC_SUPV_PROG});
        vec_is_reset_in = 1'b0;
        vbr_wdata_in = 32'hfedc_ba98;
        vbr_wr_in = 1'b1;
        tick();
        vbr_wr_in = 1'b0;
        vec_req_in = 1'b1;
        vec_num_in = 8'h01;
        tick();
        vec_req_in = 1'b0;
        check({vec_valid_out, vec_addr_out, vec_fc_out}, {1'b1, 32'hfedc_b804, FC_SUPV_DATA});
    endtask : vectors
    task automatic codes;
        logic [2:0] want;
        for (int i = 0; i < 8; i++) begin
            {cpu_space_in, supervisor_in, program_in} = i[2:0];
            tick();
            want = cpu_space_in ? FC_CPU_SPACE : supervisor_in ? (program_in ? FC_SUPV_PROG : FC_SUPV_DATA)
                : (program_in ? FC_USER_PROG : FC_USER_DATA);
            check(function_code_out, want);
            if (!cpu_space_in) begin
                check(space_sup, supervisor_in);
                check(space_four, {supervisor_in, program_in});
            end
        end
    endtask : codes
    task automatic close_out;
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (12) @(posedge clk_in);
        #1;
        check(function_code_out, FC_SUPV_PROG);
        resetn_in = 1'b1;
        accesses();
        vectors();
        codes();
        close_out();
    end
endmodule : tb
`default_nettype wire
